// ---- ars_host_model.sv ----
// Purpose: Host model that issues register frames to the bank
// Assumes: Requests launch by non-blocking assignment at a rising edge
// Notes: Released address and data lines show the inverse of the last value
`timescale 1ns/1ns
module ars_host_model
	import ars_pkg::*;
(
	input wire logic clk_in,
	output logic wr_out,
	output logic rd_out,
	output logic [ARS_ADDR_W-1:0] addr_out,
	output logic [ARS_DATA_W-1:0] wdata_out,
	output logic [ARS_CHAN_N-1:0] fsw_out
);
	// Idle frame port until the first request
	initial begin
		{wr_out, rd_out, addr_out, wdata_out, fsw_out} = '0;
	end

	// One frame: held across the sampling edge, then released as garbage so stale values never pass
	task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d, input logic [3:0] f);
		@(posedge clk_in);
		{wr_out, rd_out, addr_out, wdata_out, fsw_out} <= {w, ~w, a, d, f};
		@(posedge clk_in);
		{wr_out, rd_out, addr_out, wdata_out, fsw_out} <= {2'b00, ~a, ~d, ~f};
	endtask : access
endmodule : ars_host_model

// ---- ars_pkg.sv ----
// Purpose: Constants for the result read-back, switch and indicator register bank
// Assumes: Byte-wide registers reached through the decoded serial frame port
// Notes: Offsets are the register addresses carried by the serial frame
package ars_pkg;
	localparam int ARS_ADDR_W = 6;
	localparam int ARS_DATA_W = 8;
	localparam int ARS_SUPPLY_W = 10;
	localparam int ARS_CHAN_N = 4;
	localparam int ARS_IND_N = 8;

	// Register offsets
	localparam logic [5:0] ARS_OFS_TEMP_CHAN3 = 6'h15;
	localparam logic [5:0] ARS_OFS_TEMP_CHAN4 = 6'h16;
	localparam logic [5:0] ARS_OFS_VOLT_CHAN1 = 6'h17;
	localparam logic [5:0] ARS_OFS_VOLT_CHAN2 = 6'h18;
	localparam logic [5:0] ARS_OFS_VOLT_CHAN3 = 6'h19;
	localparam logic [5:0] ARS_OFS_VOLT_CHAN4 = 6'h1A;
	localparam logic [5:0] ARS_OFS_SUPPLY_HIGH = 6'h1B;
	localparam logic [5:0] ARS_OFS_SUPPLY_LOW = 6'h1C;
	localparam logic [5:0] ARS_OFS_SWITCH = 6'h1D;
	localparam logic [5:0] ARS_OFS_IND_LOW = 6'h1E;
	localparam logic [5:0] ARS_OFS_IND_HIGH = 6'h1F;

	// Reset values
	localparam logic [7:0] ARS_RESULT_RST = 8'h00;
	localparam logic [9:0] ARS_SUPPLY_RST = 10'h000;
	localparam logic [3:0] ARS_SWITCH_RST = 4'h0;
	localparam logic [3:0] ARS_IND_RST = 4'h0;
	localparam logic [7:0] ARS_RDATA_ZERO = 8'h00;

	// Converter result selectors on the load port
	typedef enum logic [2:0] {
		ARS_SEL_TEMP3 = 3'h0,
		ARS_SEL_TEMP4 = 3'h1,
		ARS_SEL_VOLT1 = 3'h2,
		ARS_SEL_VOLT2 = 3'h3,
		ARS_SEL_VOLT3 = 3'h4,
		ARS_SEL_VOLT4 = 3'h5,
		ARS_SEL_SUPPLY = 3'h6
	} ars_sel_t;
endpackage : ars_pkg

// ---- ars_regs.sv ----
// Purpose: Register bank for converter read-back, channel switch state and indicators
// Assumes: Frame decoder and converter run on clk_in; one access per cycle at most
// Notes: Read data appears one cycle after the read strobe
// Summary of operation
// - Channel 3 temperature result read at 15h
// - Channel 4 temperature result read at 16h
// - Four voltage results read at 17h-1Ah
// - Upper supply result bits read at 1Bh
// - Supply low bits at 1Ch, rest zero
// - Switch write uses data field only
// - Bits 3..0 drive channels 4..1 on
// - Switch bits reset off, upper bits reserved
// - Register 1Eh drives indicators 1 to 4
// - Register 1Fh drives indicators 5 to 8
`timescale 1ns/1ns
module ars_regs
	import ars_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [ARS_ADDR_W-1:0] reg_addr_in,
	input wire logic [ARS_DATA_W-1:0] reg_wdata_in,
	input wire logic [ARS_CHAN_N-1:0] frame_switch_bits_in,
	input wire logic conv_load_in,
	input wire logic [2:0] conv_sel_in,
	input wire logic [ARS_SUPPLY_W-1:0] conv_data_in,
	output logic [ARS_DATA_W-1:0] reg_rdata_out,
	output logic reg_rvalid_out,
	output logic [ARS_CHAN_N-1:0] chan_switch_on_out,
	output logic [ARS_IND_N-1:0] indicator_on_out
);
	logic [7:0] temp_value_q [2];
	logic [7:0] volt_value_q [ARS_CHAN_N];
	logic [ARS_SUPPLY_W-1:0] supply_value_q;
	logic [ARS_CHAN_N-1:0] switch_q;
	logic [3:0] ind_low_q;
	logic [3:0] ind_high_q;
	logic [7:0] rdata_q;
	logic rvalid_q;
	logic frame_switch_unused;

	// Read decode; unmapped offsets answer zero
	function automatic logic [7:0] read_mux(input logic [5:0] addr);
		logic [7:0] v;
		v = ARS_RDATA_ZERO;
		case (addr)
			ARS_OFS_TEMP_CHAN3: v = temp_value_q[0];
			ARS_OFS_TEMP_CHAN4: v = temp_value_q[1];
			ARS_OFS_VOLT_CHAN1: v = volt_value_q[0];
			ARS_OFS_VOLT_CHAN2: v = volt_value_q[1];
			ARS_OFS_VOLT_CHAN3: v = volt_value_q[2];
			ARS_OFS_VOLT_CHAN4: v = volt_value_q[3];
			ARS_OFS_SUPPLY_HIGH: v = supply_value_q[9:2];
			ARS_OFS_SUPPLY_LOW: v = {6'h00, supply_value_q[1:0]};
			ARS_OFS_SWITCH: v = {4'h0, switch_q};
			ARS_OFS_IND_LOW: v = {4'h0, ind_low_q};
			ARS_OFS_IND_HIGH: v = {4'h0, ind_high_q};
			default: v = ARS_RDATA_ZERO;
		endcase
		return v;
	endfunction : read_mux

	// Write hit on a given offset
	function automatic logic wr_hit(input logic wr, input logic [5:0] addr, input logic [5:0] ofs);
		return wr && (addr == ofs);
	endfunction : wr_hit

	// The frame's own switch bits are deliberately not consumed here
	assign frame_switch_unused = ^frame_switch_bits_in;

	// Converter results; only the converter port loads them, bus writes cannot
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			temp_value_q[0] <= ARS_RESULT_RST;
			temp_value_q[1] <= ARS_RESULT_RST;
			for (int i = 0; i < ARS_CHAN_N; i++) begin
				volt_value_q[i] <= ARS_RESULT_RST;
			end
			supply_value_q <= ARS_SUPPLY_RST;
		end else if (conv_load_in) begin
			case (conv_sel_in)
				ARS_SEL_TEMP3: temp_value_q[0] <= conv_data_in[7:0];
				ARS_SEL_TEMP4: temp_value_q[1] <= conv_data_in[7:0];
				ARS_SEL_VOLT1: volt_value_q[0] <= conv_data_in[7:0];
				ARS_SEL_VOLT2: volt_value_q[1] <= conv_data_in[7:0];
				ARS_SEL_VOLT3: volt_value_q[2] <= conv_data_in[7:0];
				ARS_SEL_VOLT4: volt_value_q[3] <= conv_data_in[7:0];
				ARS_SEL_SUPPLY: supply_value_q <= conv_data_in;
				default: ;
			endcase
		end
	end

	// Switch state comes only from the data field; reserved bits are dropped
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			switch_q <= ARS_SWITCH_RST;
		end else if (wr_hit(reg_wr_in, reg_addr_in, ARS_OFS_SWITCH)) begin
			switch_q <= reg_wdata_in[3:0];
		end
	end

	// Indicator controls, low nibble only
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ind_low_q <= ARS_IND_RST;
			ind_high_q <= ARS_IND_RST;
		end else begin
			if (wr_hit(reg_wr_in, reg_addr_in, ARS_OFS_IND_LOW)) begin
				ind_low_q <= reg_wdata_in[3:0];
			end
			if (wr_hit(reg_wr_in, reg_addr_in, ARS_OFS_IND_HIGH)) begin
				ind_high_q <= reg_wdata_in[3:0];
			end
		end
	end

	// Registered read path keeps the data output glitch free
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_q <= ARS_RDATA_ZERO;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= reg_rd_in;
			if (reg_rd_in) begin
				rdata_q <= read_mux(reg_addr_in);
			end
		end
	end

	// Outputs
	assign reg_rdata_out = rdata_q;
	assign reg_rvalid_out = rvalid_q;
	assign chan_switch_on_out = switch_q;
	assign indicator_on_out = {ind_high_q, ind_low_q};

	// Read-back checks; the byte must be the register as it stood when the strobe was taken
	a_temp3_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(reg_rd_in && reg_addr_in == ARS_OFS_TEMP_CHAN3) |=> (reg_rvalid_out && reg_rdata_out == $past(temp_value_q[0])))
		else $error("temperature 3 read mismatch");
	a_temp4_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(reg_rd_in && reg_addr_in == ARS_OFS_TEMP_CHAN4) |=> reg_rdata_out == $past(temp_value_q[1]))
		else $error("temperature 4 read mismatch");
	a_volt1_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(reg_rd_in && reg_addr_in == ARS_OFS_VOLT_CHAN1) |=> reg_rdata_out == $past(volt_value_q[0]))
		else $error("voltage 1 read mismatch");
	a_volt2_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(reg_rd_in && reg_addr_in == ARS_OFS_VOLT_CHAN2) |=> reg_rdata_out == $past(volt_value_q[1]))
		else $error("voltage 2 read mismatch");
	a_volt3_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(reg_rd_in && reg_addr_in == ARS_OFS_VOLT_CHAN3) |=> reg_rdata_out == $past(volt_value_q[2]))
		else $error("voltage 3 read mismatch");
	a_volt4_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(reg_rd_in && reg_addr_in == ARS_OFS_VOLT_CHAN4) |=> reg_rdata_out == $past(volt_value_q[3]))
		else $error("voltage 4 read mismatch");

	// Supply halves; the high byte is held against the converter word, not the register copy
	a_supply_high_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(conv_load_in && conv_sel_in == ARS_SEL_SUPPLY) ##1 (reg_rd_in && reg_addr_in == ARS_OFS_SUPPLY_HIGH)
		|=> reg_rdata_out == $past(conv_data_in[9:2], 2))
		else $error("supply high read mismatch");
	a_supply_low_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(reg_rd_in && reg_addr_in == ARS_OFS_SUPPLY_LOW) |=> (reg_rdata_out[7:2] == 6'h00
		&& reg_rdata_out[1:0] == $past(supply_value_q[1:0])))
		else $error("supply low read mismatch");

	// Switch register: data field only, held between writes
	a_switch_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(reg_wr_in && reg_addr_in == ARS_OFS_SWITCH) |=> chan_switch_on_out == $past(reg_wdata_in[3:0]))
		else $error("switch state not taken from data field");
	a_switch_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!(reg_wr_in && reg_addr_in == ARS_OFS_SWITCH) |=> $stable(chan_switch_on_out))
		else $error("switch state changed without a write");
	a_switch_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(reg_rd_in && reg_addr_in == ARS_OFS_SWITCH) |=> reg_rdata_out == {4'h0, $past(chan_switch_on_out)})
		else $error("switch readback mismatch");

	// Indicator writes land one cycle after the strobe
	a_ind_low_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(reg_wr_in && reg_addr_in == ARS_OFS_IND_LOW) |=> indicator_on_out[3:0] == $past(reg_wdata_in[3:0]))
		else $error("indicator 1-4 write mismatch");
	a_ind_high_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(reg_wr_in && reg_addr_in == ARS_OFS_IND_HIGH) |=> indicator_on_out[7:4] == $past(reg_wdata_in[3:0]))
		else $error("indicator 5-8 write mismatch");

	// A bus write to the channel 3 temperature result at 15h must leave it alone
	a_result_readonly: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(reg_wr_in && reg_addr_in == ARS_OFS_TEMP_CHAN3 && !conv_load_in) |=> $stable(temp_value_q[0]))
		else $error("result register changed by a write");

	// Indicator read-back shows zeros in the reserved upper nibble
	a_ind_low_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(reg_rd_in && reg_addr_in == ARS_OFS_IND_LOW) |=> reg_rdata_out == {4'h0, $past(indicator_on_out[3:0])})
		else $error("indicator 1-4 readback mismatch");
	a_ind_high_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(reg_rd_in && reg_addr_in == ARS_OFS_IND_HIGH) |=> reg_rdata_out == {4'h0, $past(indicator_on_out[7:4])})
		else $error("indicator 5-8 readback mismatch");

	// Indicators only move on a write to one of their own offsets
	a_ind_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!(reg_wr_in && (reg_addr_in == ARS_OFS_IND_LOW || reg_addr_in == ARS_OFS_IND_HIGH)) |=> $stable(indicator_on_out))
		else $error("indicators changed without a write");

	// Unmapped offsets answer zero so a host never reads a stale byte
	a_unmapped_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(reg_rd_in && (reg_addr_in < ARS_OFS_TEMP_CHAN3 || reg_addr_in > ARS_OFS_IND_HIGH)) |=> reg_rdata_out == ARS_RDATA_ZERO)
		else $error("unmapped read not zero");

	// Every strobe gets one valid pulse a cycle later, and the byte holds between reads
	a_read_valid: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		reg_rvalid_out == $past(reg_rd_in))
		else $error("read valid pulse misplaced");
	a_rdata_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("read data changed without a read");

	// Reset must leave every output transistor and indicator off
	a_reset_off: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$rose(reset_n_in) |-> (chan_switch_on_out == ARS_SWITCH_RST && indicator_on_out == {ARS_IND_RST, ARS_IND_RST}))
		else $error("outputs not off after reset");
endmodule : ars_regs

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the read-back, switch and indicator bank
// Assumes: Host model drives the register port, the bench drives the converter port
// Notes: Read results are queued at issue and matched when the valid pulse shows
`timescale 1ns/1ns
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin fails++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb_top
	import ars_pkg::*;
;
	logic clk_in, reset_n_in, host_wr, host_rd, load, rvalid;
	logic [5:0] addr;
	logic [7:0] wdata, rdata, seed, ind, e_v;
	logic [7:0] exp_res [6];
	logic [7:0] exp_q [$];
	logic [3:0] fsw, sw;
	logic [2:0] sel;
	logic [9:0] cdata;
	int fails, checks_done, cycles;

	ars_host_model host (.clk_in(clk_in), .wr_out(host_wr), .rd_out(host_rd), .addr_out(addr), .wdata_out(wdata),
		.fsw_out(fsw));
	ars_regs uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_wr_in(host_wr), .reg_rd_in(host_rd),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .frame_switch_bits_in(fsw), .conv_load_in(load),
		.conv_sel_in(sel), .conv_data_in(cdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
		.chan_switch_on_out(sw), .indicator_on_out(ind));

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	task automatic give_verdict();
		`CHK("pending reads", 0, exp_q.size())
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.access(1'b0, a, 8'h00, 4'h0);
	endtask : rd

	task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [3:0] f);
		host.access(1'b1, a, d, f);
		#1;
	endtask : wr

	task automatic ld(input logic [2:0] s, input logic [9:0] d);
		@(posedge clk_in);
		{load, sel, cdata} <= {1'b1, s, d};
		@(posedge clk_in);
		{load, sel, cdata} <= {1'b0, ~s, ~d};
	endtask : ld

	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	// Watchdog and read monitor; a valid pulse with no note pending is itself a fault
	always @(negedge clk_in) begin
		if (rvalid === 1'b1) begin
			if (exp_q.size() == 0) `CHK("stray rvalid", 1'b0, rvalid)
			else begin
				e_v = exp_q.pop_front();
				`CHK("rdata", e_v, rdata)
			end
		end
		cycles++;
		if (cycles > 2000) begin
			fails++;
			give_verdict();
		end
	end

	// Main sequence
	initial begin
		{reset_n_in, load, sel, cdata} = '0;
		seed = 8'h41;
		repeat (4) @(posedge clk_in);
		reset_n_in <= 1'b1;
		`CHK("switch", 4'h0, sw)
		`CHK("indicators", 8'h00, ind)
		for (int a = 'h15; a <= 'h1F; a++) rd(6'(a), 8'h00);
		$display("test reset done");
		// Upper bits set on 8-bit results must not leak into the byte
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			exp_res[i] = seed;
			ld(3'(i), {2'b11, seed});
		end
		ld(3'h7, 10'h3FF);
		wr(ARS_OFS_TEMP_CHAN3, ~exp_res[0], 4'hF);
		for (int i = 0; i < 6; i++) rd(ARS_OFS_TEMP_CHAN3 + 6'(i), exp_res[i]);
		seed = lfsr(seed);
		// High byte is read in the cycle right after the load, so the converter word itself is checked
		fork
			ld(ARS_SEL_SUPPLY, {seed, 2'b10});
			begin
				@(posedge clk_in);
				rd(ARS_OFS_SUPPLY_HIGH, seed);
			end
		join
		rd(ARS_OFS_SUPPLY_LOW, 8'h02);
		wr(6'h20, 8'hFF, 4'h0);
		rd(6'h20, 8'h00);
		$display("test results done");
		// Frame switch bits always disagree with the data field
		for (int v = 0; v < 16; v++) begin
			wr(ARS_OFS_SWITCH, {4'hF, 4'(v)}, ~4'(v));
			`CHK("switch", 4'(v), sw)
			rd(ARS_OFS_SWITCH, {4'h0, 4'(v)});
		end
		$display("test switch done");
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			wr(ARS_OFS_IND_LOW, seed, 4'h0);
			wr(ARS_OFS_IND_HIGH, ~seed, 4'h0);
			`CHK("indicators", {~seed[3:0], seed[3:0]}, ind)
			rd(ARS_OFS_IND_LOW, {4'h0, seed[3:0]});
			rd(ARS_OFS_IND_HIGH, {4'h0, ~seed[3:0]});
		end
		$display("test indicators done");
		// Mid-run reset with channels and indicators lit; a gap first lets the last read answer
		@(posedge clk_in);
		reset_n_in <= 1'b0;
		@(posedge clk_in);
		`CHK("switch", 4'h0, sw)
		`CHK("indicators", 8'h00, ind)
		reset_n_in <= 1'b1;
		$display("test reset again done");
		repeat (3) @(posedge clk_in);
		give_verdict();
	end
endmodule : tb_top
